// [logic/iop_consts.svh]
// Constant definitions for the I/O port pad controller
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH
`define IOP_NBANK        11
`define IOP_NPIN         88
`define IOP_BANK_LAST    4'd10
`define IOP_BANK_SECOND  4'd1
`define IOP_BANK_CFG_LO  4'd3
`define IOP_CFG_TOP      10
`define IOP_BANK_SHIFT   3
`define IOP_PIN_MASK     3'h7
`define IOP_CHAN_W       4
`define IOP_ANA_PINS     24
`define IOP_GPU_BIT      7
`define IOP_IDX_BANK_END 6'h21
`define IOP_IDX_CTRL2    6'h21
`define IOP_IDX_WPU      6'h22
`define IOP_IDX_PADCFG   6'h23
`define IOP_IDX_ODA      6'h24
`define IOP_IDX_ODB      6'h25
`define IOP_IDX_ANA_A    6'h26
`define IOP_IDX_ANA_B    6'h27
`define IOP_IDX_ANA_C    6'h28
`define IOP_STRIDE       6'h03
`define IOP_DIR_RST      8'hff
`define IOP_LAT_RST      8'h00
`define IOP_CTRL2_RST    8'h80
`define IOP_WPU_RST      8'h00
`define IOP_CFG_RST      8'h00
`define IOP_OD_RST       8'h00
`define IOP_ANA_RST      8'hff
`define IOP_PRESENT_ALL  11'h7ff
`define IOP_ZERO8        8'h00
`define IOP_PAD24        24'h000000
`endif

// [logic/iop_pkg.sv]
// Types shared by the I/O port pad controller
package iop_pkg;
    // Register kind within one bank's triplet
    typedef enum logic [1:0] {
        IOP_KIND_PIN = 2'b00,
        IOP_KIND_LAT = 2'b01,
        IOP_KIND_DIR = 2'b10,
        IOP_KIND_BAD = 2'b11
    } iop_kind_t;
endpackage : iop_pkg

// [logic/iop_pad_ctrl.sv]
// I/O port pad controller: bank registers, pad drive, pull-ups, open-drain
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "iop_consts.svh"

module iop_pad_ctrl
    import iop_pkg::*;
#(
    parameter logic [10:0] BANK_PRESENT = `IOP_PRESENT_ALL
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic [87:0]  pad_in,
    output logic      [87:0]  pad_out,
    output logic      [87:0]  pad_oe,
    output logic      [87:0]  pad_pullup,
    output logic      [87:0]  pad_ibuf_dis,
    input  wire logic [87:0]  periph_en,
    input  wire logic [87:0]  periph_out,
    input  wire logic [87:0]  periph_oe,
    input  wire logic [87:0]  periph_odcap,
    input  wire logic [351:0] periph_chan
);

    // Bank index from a register index
    function automatic logic [3:0] f_bank(input logic [5:0] idx);
        logic [5:0] q;
        q = idx / `IOP_STRIDE;
        return q[3:0];
    endfunction : f_bank

    // Register kind from a register index
    function automatic iop_kind_t f_kind(input logic [5:0] idx);
        logic [5:0] r;
        r = idx % `IOP_STRIDE;
        return iop_kind_t'(r[1:0]);
    endfunction : f_kind

    // Implemented pad config bits: bit k serves bank (top - k)
    function automatic logic [7:0] f_cfg_mask(input logic [10:0] pres);
        logic [7:0] m;
        m = `IOP_ZERO8;
        for (int k = 0; k < 8; k++) begin
            m[k] = pres[`IOP_CFG_TOP - k];
        end
        return m;
    endfunction : f_cfg_mask

    localparam logic [7:0] CFG_MASK = f_cfg_mask(BANK_PRESENT);

    logic [7:0]  dir_ff [0:10];
    logic [7:0]  lat_ff [0:10];
    logic [7:0]  ctrl2_ff;
    logic [7:0]  wpu_ff;
    logic [7:0]  pucfg_ff;
    logic [7:0]  oda_ff;
    logic [7:0]  odb_ff;
    logic [7:0]  ana_a_ff;
    logic [7:0]  ana_b_ff;
    logic [7:0]  ana_c_ff;
    logic [87:0] sync1_ff;
    logic [87:0] sync2_ff;
    logic [87:0] sync3_ff;
    logic [87:0] pin_lvl_ff;
    logic [87:0] pad_out_ff;
    logic [87:0] pad_oe_ff;
    logic [87:0] pad_pu_ff;
    logic [87:0] ibuf_dis_ff;
    logic        ack_ff;
    logic [31:0] dat_o_ff;
    logic [87:0] nxt_out;
    logic [87:0] nxt_oe;
    logic [87:0] nxt_pu;
    logic [87:0] dir_flat;
    logic [87:0] lat_flat;
    logic [87:0] ana_flat;
    logic [87:0] od_act;
    logic [7:0]  nxt_rd;

    // Request decode; writes land on the acknowledging edge
    wire         req      = wb_cyc_i & wb_stb_i;
    wire [5:0]   idx      = wb_adr_i[7:2];
    wire         in_banks = idx < `IOP_IDX_BANK_END;
    wire [3:0]   rbank    = f_bank(idx);
    iop_kind_t   rkind;
    assign rkind = f_kind(idx);
    wire         wr_fire  = req & ack_ff & wb_we_i & wb_sel_i[0];
    wire [7:0]   wbyte    = wb_dat_i[7:0];
    wire [15:0]  od_all   = {odb_ff, oda_ff};

    // Three-stage pin synchroniser; the first stage feeds only the second
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Level accepted only where stages two and three agree, filtering metastability
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_lvl_ff <= '0;
        end else begin
            pin_lvl_ff <= (sync3_ff & ~(sync2_ff ^ sync3_ff))
                        | (pin_lvl_ff & (sync2_ff ^ sync3_ff));
        end
    end

    // Output latches; pin-level and latch writes both land here
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < `IOP_NBANK; b++) begin
                lat_ff[b] <= `IOP_LAT_RST;
            end
        end else if (wr_fire && in_banks
                     && (rkind == IOP_KIND_PIN || rkind == IOP_KIND_LAT)) begin
            lat_ff[rbank] <= wbyte;
        end
    end

    // Direction registers; reset leaves every pin an input
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < `IOP_NBANK; b++) begin
                dir_ff[b] <= `IOP_DIR_RST;
            end
        end else if (wr_fire && in_banks && rkind == IOP_KIND_DIR) begin
            dir_ff[rbank] <= wbyte;
        end
    end

    // Pad configuration registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl2_ff <= `IOP_CTRL2_RST;
            wpu_ff   <= `IOP_WPU_RST;
            pucfg_ff <= `IOP_CFG_RST;
            oda_ff   <= `IOP_OD_RST;
            odb_ff   <= `IOP_OD_RST;
            ana_a_ff <= `IOP_ANA_RST;
            ana_b_ff <= `IOP_ANA_RST;
            ana_c_ff <= `IOP_ANA_RST;
        end else if (wr_fire) begin
            if (idx == `IOP_IDX_CTRL2) begin
                ctrl2_ff[`IOP_GPU_BIT] <= wbyte[`IOP_GPU_BIT];
            end else if (idx == `IOP_IDX_WPU) begin
                wpu_ff <= wbyte;
            end else if (idx == `IOP_IDX_PADCFG) begin
                pucfg_ff <= wbyte & CFG_MASK;
            end else if (idx == `IOP_IDX_ODA) begin
                oda_ff <= wbyte;
            end else if (idx == `IOP_IDX_ODB) begin
                odb_ff <= wbyte;
            end else if (idx == `IOP_IDX_ANA_A) begin
                ana_a_ff <= wbyte;
            end else if (idx == `IOP_IDX_ANA_B) begin
                ana_b_ff <= wbyte;
            end else if (idx == `IOP_IDX_ANA_C) begin
                ana_c_ff <= wbyte;
            end
        end
    end

    // Flattened views of the banked storage
    always_comb begin
        dir_flat = '0;
        lat_flat = '0;
        for (int b = 0; b < `IOP_NBANK; b++) begin
            dir_flat[b*8 +: 8] = dir_ff[b];
            lat_flat[b*8 +: 8] = lat_ff[b];
        end
        ana_flat = '0;
        ana_flat[`IOP_ANA_PINS-1:0] = {ana_c_ff, ana_b_ff, ana_a_ff};
    end

    // Per-pad drive, direction and pull-up selection
    always_comb begin
        nxt_out = '0;
        nxt_oe  = '0;
        nxt_pu  = '0;
        od_act  = '0;
        for (int i = 0; i < `IOP_NPIN; i++) begin
            int          b;
            logic [3:0]  ch;
            b  = i >> `IOP_BANK_SHIFT;
            ch = periph_chan[i*`IOP_CHAN_W +: `IOP_CHAN_W];
            od_act[i] = periph_en[i] & periph_odcap[i] & od_all[ch];
            if (periph_en[i]) begin
                if (od_act[i]) begin
                    nxt_out[i] = 1'b0;
                    nxt_oe[i]  = periph_oe[i] & ~periph_out[i];
                end else begin
                    nxt_out[i] = periph_out[i];
                    nxt_oe[i]  = periph_oe[i];
                end
            end else begin
                nxt_out[i] = lat_flat[i];
                nxt_oe[i]  = ~dir_flat[i];
            end
            // Pull-ups act only on pads that are not driving
            if (b == `IOP_BANK_SECOND) begin
                nxt_pu[i] = ~ctrl2_ff[`IOP_GPU_BIT]
                          & wpu_ff[i & `IOP_PIN_MASK] & ~nxt_oe[i];
            end else if (b >= `IOP_BANK_CFG_LO) begin
                nxt_pu[i] = pucfg_ff[`IOP_CFG_TOP - b] & ~nxt_oe[i];
            end else begin
                nxt_pu[i] = 1'b0;
            end
        end
    end

    // Registered pad outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_out_ff  <= '0;
            pad_oe_ff   <= '0;
            pad_pu_ff   <= '0;
            ibuf_dis_ff <= '1;
        end else begin
            pad_out_ff  <= nxt_out;
            pad_oe_ff   <= nxt_oe;
            pad_pu_ff   <= nxt_pu;
            ibuf_dis_ff <= ana_flat;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rd = `IOP_ZERO8;
        if (in_banks && rkind == IOP_KIND_PIN) begin
            nxt_rd = pin_lvl_ff[rbank*8 +: 8] & ~ana_flat[rbank*8 +: 8];
        end else if (in_banks && rkind == IOP_KIND_LAT) begin
            nxt_rd = lat_ff[rbank];
        end else if (in_banks && rkind == IOP_KIND_DIR) begin
            nxt_rd = dir_ff[rbank];
        end else if (idx == `IOP_IDX_CTRL2) begin
            nxt_rd = ctrl2_ff;
        end else if (idx == `IOP_IDX_WPU) begin
            nxt_rd = wpu_ff;
        end else if (idx == `IOP_IDX_PADCFG) begin
            nxt_rd = pucfg_ff;
        end else if (idx == `IOP_IDX_ODA) begin
            nxt_rd = oda_ff;
        end else if (idx == `IOP_IDX_ODB) begin
            nxt_rd = odb_ff;
        end else if (idx == `IOP_IDX_ANA_A) begin
            nxt_rd = ana_a_ff;
        end else if (idx == `IOP_IDX_ANA_B) begin
            nxt_rd = ana_b_ff;
        end else if (idx == `IOP_IDX_ANA_C) begin
            nxt_rd = ana_c_ff;
        end
    end

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Read data captured with the request, held until the next one
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dat_o_ff <= '0;
        end else if (req && !ack_ff) begin
            dat_o_ff <= {`IOP_PAD24, nxt_rd};
        end
    end

    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = dat_o_ff;
    assign pad_out      = pad_out_ff;
    assign pad_oe       = pad_oe_ff;
    assign pad_pullup   = pad_pu_ff;
    assign pad_ibuf_dis = ibuf_dis_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_req_new;
        req && !ack_ff;
    endsequence

    sequence s_ack_pulse;
        ack_ff ##1 !ack_ff;
    endsequence

    a_bus_ack_pulse: assert property (s_req_new |=> s_ack_pulse)
        else $error("ack not a one-cycle answer");

    a_pin_read_lvl: assert property (
        s_req_new and in_banks && rkind == IOP_KIND_PIN
        |=> dat_o_ff[7:0] == $past(pin_lvl_ff[rbank*8 +: 8] & ~ana_flat[rbank*8 +: 8]))
        else $error("pin read differs from pin level");

    a_pin_wr_latch: assert property (
        wr_fire && in_banks && rkind == IOP_KIND_PIN
        |=> lat_ff[$past(rbank)] == $past(wbyte))
        else $error("pin write did not load latch");

    a_lat_readback: assert property (
        s_req_new and in_banks && rkind == IOP_KIND_LAT
        |=> dat_o_ff[7:0] == $past(lat_ff[rbank]))
        else $error("latch read wrong");

    a_dir_hiz: assert property (
        ($past(~periph_en & dir_flat) & pad_oe_ff) == '0)
        else $error("input pin driven");

    a_dir_drive: assert property (
        ($past(~periph_en & ~dir_flat) & ~(pad_oe_ff & ~(pad_out_ff ^ $past(lat_flat)))) == '0)
        else $error("output pin not driving latch");

    a_od_no_high: assert property (
        (($past(od_act & periph_oe) & ~(pad_oe_ff ^ $past(periph_out)))
         | ($past(od_act) & pad_oe_ff & pad_out_ff)) == '0)
        else $error("open-drain pin not pulled low or released");

    a_no_pull_banks: assert property (
        pad_pu_ff[7:0] == '0 && pad_pu_ff[23:16] == '0)
        else $error("pull-up on first or third bank");

    a_cfg_absent: assert property ((pucfg_ff & ~CFG_MASK) == '0)
        else $error("absent bank config bit set");

    a_global_pull_off: assert property (
        $past(ctrl2_ff[`IOP_GPU_BIT]) |-> pad_pu_ff[15:8] == '0)
        else $error("second bank pulled while globally off");

endmodule : iop_pad_ctrl

// [dv/iop_pin_model.sv]
// Behavioural model of the board pins and the sources outside the port
`timescale 1ns/1ps

module iop_pin_model (
    input  wire logic [87:0] pad_out,
    input  wire logic [87:0] pad_oe,
    input  wire logic [87:0] pad_pullup,
    input  wire logic [87:0] ext_en,
    input  wire logic [87:0] ext_val,
    input  wire logic [87:0] board_pu,
    output logic      [87:0] pad_in
);
    // Port drive wins, then an outside source, then a pull-up; a floating pin
    // shows the inverse of the pad value so a stale level never passes for a match
    always_comb begin
        for (int i = 0; i < 88; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pullup[i] || board_pu[i]) begin
                pad_in[i] = 1'b1; // Port or board pull-up on released drains
            end else begin
                pad_in[i] = ~pad_out[i];
            end
        end
    end
endmodule : iop_pin_model

// [dv/io_port_pad_control_test.sv]
// Self-checking bench for the I/O port pad controller
`timescale 1ns/1ps

module io_port_pad_control_test;
    import iop_pkg::*;
    typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] exp;} iop_row_t;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         wb_cyc_i = 1'b0;
    logic         wb_stb_i = 1'b0;
    logic         wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h00000000;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic [87:0]  pad_in, pad_out, pad_oe, pad_pullup, pad_ibuf_dis;
    logic [87:0]  periph_en = '0, periph_out = '0, periph_oe = '0, periph_odcap = '0;
    logic [351:0] periph_chan = '0;
    logic [87:0]  ext_en = '0, ext_val = '0, board_pu = '0;
    logic [7:0]   rd;
    int           bad_count = 0;
    int           check_count = 0;
    // Last bank absent so its pull-up enable must read 0
    // Index 0x20 is the last bank's direction register, the end of the bank range
    iop_row_t     rows [8] = '{'{6'h23, 8'ha5, 8'ha4}, '{6'h23, 8'hff, 8'hfe},
        '{6'h24, 8'h5a, 8'h5a}, '{6'h25, 8'hc3, 8'hc3}, '{6'h0d, 8'h3c, 8'h3c},
        '{6'h3f, 8'hff, 8'h00}, '{6'h22, 8'h0f, 8'h0f}, '{6'h20, 8'h5a, 8'h5a}};

    always #10 ref_clk = ~ref_clk;

    iop_pad_ctrl #(.BANK_PRESENT(11'h3ff)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_ibuf_dis(pad_ibuf_dis), .periph_en(periph_en), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_odcap(periph_odcap), .periph_chan(periph_chan));

    iop_pin_model pins_u (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .board_pu(board_pu), .pad_in(pad_in));

    task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One classic cycle; entered just after a rising edge, leaves one idle cycle behind
    // A lost ack is left to the watchdog; the master itself never gives up
    task automatic wb_cycle(input logic we, input logic [5:0] idx, input logic [7:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_cycle

    // Pads follow a write two edges on; pin reads need the synchroniser too
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Whole run is well under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        final_report();
    end

    initial begin
        tick(3);
        sys_rst <= 1'b0;
        tick(2);
        chk("oe after reset", pad_oe, 88'h0);
        chk("analog ibuf", pad_ibuf_dis[23:0], 24'hffffff);
        for (int i = 6'h22; i <= 6'h25; i++) begin
            wb_cycle(1'b0, 6'(i), 8'h00);
            chk("reset value", rd, 8'h00);
        end
        $display("reset test done");
        foreach (rows[i]) begin
            wb_cycle(1'b1, rows[i].idx, rows[i].wd);
            wb_cycle(1'b0, rows[i].idx, 8'h00);
            chk("register row", rd, rows[i].exp);
        end
        $display("register rows done");
        // Bank four: pin-level write lands in the latch, low nibble input
        ext_en[35:32] <= 4'hf;
        ext_val[35:32] <= 4'h3;
        wb_cycle(1'b1, 6'h0c, 8'ha5);
        wb_cycle(1'b0, 6'h0d, 8'h00);
        chk("latch via pin reg", rd, 8'ha5);
        wb_cycle(1'b1, 6'h0e, 8'h0f);
        wb_cycle(1'b1, 6'h23, 8'h40); // Bit 6 serves bank index 4
        tick(6);
        chk("bank4 oe", pad_oe[39:32], 8'hf0);
        chk("bank4 out", pad_out[39:36], 4'ha);
        chk("bank4 pullup", pad_pullup[39:32], 8'h0f);
        wb_cycle(1'b0, 6'h0c, 8'h00);
        chk("pin levels", rd, 8'ha3);
        wb_cycle(1'b1, 6'h23, 8'h00);
        tick(2);
        chk("bank4 pullup off", pad_pullup[39:32], 8'h00);
        $display("port test done");
        // Second bank pull-ups: per-pin select, then global active-low bit
        wb_cycle(1'b1, 6'h27, 8'h00);
        wb_cycle(1'b1, 6'h22, 8'h81);
        wb_cycle(1'b1, 6'h21, 8'h00);
        tick(2);
        chk("bank2 pullup", pad_pullup[15:8], 8'h81);
        chk("no pullup banks", {pad_pullup[23:16], pad_pullup[7:0]}, 16'h0);
        wb_cycle(1'b1, 6'h21, 8'h80);
        tick(2);
        chk("bank2 global off", pad_pullup[15:8], 8'h00);
        // Analog pins read 0 until made digital
        ext_en[7:0] <= 8'hff;
        ext_val[7:0] <= 8'h6c;
        tick(6);
        wb_cycle(1'b0, 6'h00, 8'h00);
        chk("analog read", rd, 8'h00);
        wb_cycle(1'b1, 6'h26, 8'h00);
        tick(6);
        chk("digital ibuf", pad_ibuf_dis[7:0], 8'h00);
        wb_cycle(1'b0, 6'h00, 8'h00);
        chk("digital read", rd, 8'h6c);
        $display("pull-up and analog test done");
        // Peripherals on pins 40 (uart1, control A bit 2) and 41 (cap4, control B bit 1)
        periph_en[41:40] <= 2'b11;
        periph_out[41:40] <= 2'b11;
        periph_oe[41:40] <= 2'b11;
        periph_odcap[41:40] <= 2'b11;
        periph_chan[167:160] <= 8'h92;
        board_pu[41:40] <= 2'b11;
        wb_cycle(1'b1, 6'h24, 8'h00);
        wb_cycle(1'b1, 6'h25, 8'h00);
        tick(2);
        chk("push-pull oe", pad_oe[41:40], 2'b11);
        chk("push-pull out", pad_out[41:40], 2'b11);
        wb_cycle(1'b1, 6'h24, 8'h04);
        wb_cycle(1'b1, 6'h25, 8'h02);
        tick(2);
        chk("drain released", pad_oe[41:40], 2'b00);
        periph_out[41:40] <= 2'b00;
        tick(3);
        chk("drain low oe", pad_oe[41:40], 2'b11);
        chk("drain low out", pad_out[41:40], 2'b00);
        $display("open-drain test done");
        // Mid-run reset: pull-up and open-drain bits set beforehand must clear
        wb_cycle(1'b1, 6'h23, 8'hff);
        tick(2);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(2);
        chk("pull-ups after reset", pad_pullup, 88'h0);
        wb_cycle(1'b0, 6'h24, 8'h00);
        chk("drain bits after reset", rd, 8'h00);
        wb_cycle(1'b0, 6'h25, 8'h00);
        chk("drain bits b after reset", rd, 8'h00);
        $display("mid-run reset test done");
        final_report();
    end
endmodule : io_port_pad_control_test
